//--- hw/filter_cfg_pkg.sv
// Purpose: constants for the setup 0 filter configuration block
// Assumes: 16-bit register, modulator clock is the core clock
// Notes:   rates in milli-samples per second, settling in microseconds
package filter_cfg_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [5:0]  FILT_CFG_ADDR    = 6'h28;
   localparam logic [15:0] FILT_CFG_RESET   = 16'h0500;
   localparam logic [15:0] TABLE_MODE_MASK  = 16'h8F7F;
   localparam logic [15:0] DIRECT_MODE_MASK = 16'hFFFF;
   localparam logic [15:0] REG_ZERO         = 16'h0000;
   localparam int DIRECT_BIT = 15;
   localparam int RATIO_MSB  = 14;
   localparam int RSVD_HI    = 14;
   localparam int RSVD_LO    = 12;
   localparam int PF_EN_BIT  = 11;
   localparam int PF_SEL_MSB = 10;
   localparam int PF_SEL_LSB = 8;
   localparam int RSVD_BIT   = 7;
   localparam int ORDER_MSB  = 6;
   localparam int ORDER_LSB  = 5;
   localparam int RATE_MSB   = 4;

   // ****************************************************************
   // encodings
   // ****************************************************************
   localparam logic [1:0] ORDER_SINC5_SINC1 = 2'h0;
   localparam logic [1:0] ORDER_SINC3       = 2'h3;
   localparam logic [2:0] PF_27SPS          = 3'h2;
   localparam logic [2:0] PF_21SPS          = 3'h3;
   localparam logic [2:0] PF_20SPS          = 3'h5;
   localparam logic [2:0] PF_16SPS          = 3'h6;
   localparam logic [4:0] RATE_CODE_MAX     = 5'h16;
   localparam logic [4:0] RATE_CODE_TOP     = 5'h05;
   localparam int         DECIM_FACTOR      = 32;

   // ****************************************************************
   // rate and postfilter tables
   // ****************************************************************
   localparam logic [31:0] RATE_MSPS [0:22] = '{
      32'd31250000, 32'd31250000, 32'd31250000, 32'd31250000,
      32'd31250000, 32'd31250000, 32'd15625000, 32'd10417000,
      32'd5208000,  32'd2597000,  32'd1007000,  32'd503800,
      32'd381000,   32'd200300,   32'd100200,   32'd59520,
      32'd49680,    32'd20010,    32'd16630,    32'd10000,
      32'd5000,     32'd2500,     32'd1250};
   localparam logic [31:0] PF_RATE_MSPS [0:3] =
      '{32'd27000, 32'd21250, 32'd20000, 32'd16670};
   localparam logic [6:0]  PF_REJ_DB [0:3] =
      '{7'd47, 7'd62, 7'd86, 7'd92};
   localparam logic [15:0] PF_SETTLE_US [0:3] =
      '{16'd36700, 16'd40000, 16'd50000, 16'd60000};

   typedef enum logic [1:0] {
      CONV_IDLE    = 2'b00,
      CONV_RESTART = 2'b01,
      CONV_RUN     = 2'b11
   } conv_state_e;
endpackage

//--- hw/filter_rate_lookup.sv
// Purpose: maps configuration fields to nominal rate and postfilter data
// Assumes: purely combinational; caller registers the results
// Notes:   unlisted encodings report cfg_valid low and zero figures
`timescale 1ns/1ps
module filter_rate_lookup
   import filter_cfg_pkg::*;
(
   // configuration fields
   input  wire logic        direct_mode,
   input  wire logic        postfilter_active,
   input  wire logic [2:0]  postfilter_select,
   input  wire logic [1:0]  filter_order,
   input  wire logic [4:0]  output_rate_code,
   // decoded figures
   output logic      [31:0] rate_msps,
   output logic      [6:0]  rejection_db,
   output logic      [15:0] settling_us,
   output logic             cfg_valid
);
   logic [2:0] pf_idx;

   always_comb begin
      rate_msps    = '0;
      rejection_db = '0;
      settling_us  = '0;
      cfg_valid    = 1'b0;
      pf_idx       = 3'h4;
      case (postfilter_select)
         PF_27SPS: pf_idx = 3'h0;
         PF_21SPS: pf_idx = 3'h1;
         PF_20SPS: pf_idx = 3'h2;
         PF_16SPS: pf_idx = 3'h3;
         default:  pf_idx = 3'h4;
      endcase
      if (direct_mode) begin
         // rate set by decimation ratio, see the tick output
         cfg_valid = 1'b1;
      end else if (postfilter_active) begin
         if (!pf_idx[2]) begin
            rate_msps    = PF_RATE_MSPS[pf_idx[1:0]];
            rejection_db = PF_REJ_DB[pf_idx[1:0]];
            settling_us  = PF_SETTLE_US[pf_idx[1:0]];
            cfg_valid    = 1'b1;
         end
      end else if (output_rate_code <= RATE_CODE_MAX &&
                   (filter_order == ORDER_SINC5_SINC1 ||
                    filter_order == ORDER_SINC3)) begin
         rate_msps = RATE_MSPS[output_rate_code];
         cfg_valid = 1'b1;
      end
   end
endmodule // filter_rate_lookup

//--- hw/filter_config_setup_decode.sv
// Purpose: setup 0 filter configuration register, decode and restart
// Assumes: core_clk is the modulator clock; register port is synchronous
// Notes:   writes abort the running conversion and restart at channel 0
// Notes on behaviour
// - the setup 0 filter word is 16 bits at 0x28 and resets to 0x0500.
// - any write to 0x28 aborts the conversion and restarts at the first channel.
// - with bit 15 set, bits 14 to 0 are a sinc3 ratio and all else is off.
// - in direct mode one output comes every 32 times the ratio clocks.
// - bit 11 turns the 50/60 Hz postfilter on, and resets to off.
// - postfilter codes 010 and 011 give 27 and 21.25 SPS.
// - postfilter codes 101 (reset) and 110 give 20 and 16.67 SPS.
// - order 00 picks sinc5 plus sinc1 and 11 picks sinc3.
// - bits 4 to 0 set the output rate for the sinc5 plus sinc1 and the sinc3 paths.
// - rate codes 0 to 5 give 31250 SPS, 6 to 8 give 15625 to 5208 SPS.
// - rate codes 9 to 22 give 2597 down to 1.25 SPS.
`timescale 1ns/1ps
module filter_config_setup_decode
   import filter_cfg_pkg::*;
#(
   parameter int CH_W = 4
)(
   // clock and reset
   input  wire logic            core_clk,
   input  wire logic            rst,
   // register port
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   input  wire logic [5:0]      reg_addr,
   input  wire logic [15:0]     reg_wdata,
   output logic      [15:0]     reg_rdata,
   output logic                 reg_hit,
   // conversion sequence
   input  wire logic            conv_enable,
   input  wire logic            conv_done,
   input  wire logic [CH_W-1:0] channel_count,
   output logic                 conv_abort,
   output logic                 seq_restart,
   output logic      [CH_W-1:0] channel_idx,
   output logic                 direct_tick,
   // decoded configuration
   output logic                 direct_mode,
   output logic      [14:0]     decim_ratio,
   output logic                 postfilter_enable,
   output logic                 postfilter_active,
   output logic      [2:0]      postfilter_select,
   output logic                 sinc3_selected,
   output logic      [1:0]      filter_order,
   output logic      [4:0]      output_rate_code,
   output logic      [31:0]     rate_msps,
   output logic      [6:0]      rejection_db,
   output logic      [15:0]     settling_us,
   output logic                 cfg_valid
);
   // ****************************************************************
   // functions
   // ****************************************************************
   function automatic logic [15:0] masked_write(input logic [15:0] d);
      masked_write = d[DIRECT_BIT] ? (d & DIRECT_MODE_MASK)
                                   : (d & TABLE_MODE_MASK);
   endfunction

   function automatic logic [19:0] tick_period(input logic [14:0] r);
      tick_period = 20'(r) * 20'(DECIM_FACTOR);
   endfunction

   // ****************************************************************
   // configuration register
   // ****************************************************************
   logic [15:0]       cfg_ff,    nxt_cfg;
   logic [15:0]       rdata_ff,  nxt_rdata;
   logic              abort_ff,  nxt_abort;
   logic              wr_hit;
   logic [31:0]       lk_rate;
   logic [6:0]        lk_rej;
   logic [15:0]       lk_settle;
   logic              lk_valid;
   logic [31:0]       rate_ff;
   logic [6:0]        rej_ff;
   logic [15:0]       settle_ff;
   logic              valid_ff;

   assign reg_hit = (reg_addr == FILT_CFG_ADDR);
   assign wr_hit  = reg_wr && reg_hit;

   always_comb begin
      nxt_cfg   = cfg_ff;
      nxt_rdata = rdata_ff;
      nxt_abort = wr_hit;
      if (wr_hit) begin
         nxt_cfg = masked_write(reg_wdata);
      end
      if (reg_rd) begin
         nxt_rdata = reg_hit ? cfg_ff : REG_ZERO;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_ff    <= FILT_CFG_RESET;
         rdata_ff  <= REG_ZERO;
         abort_ff  <= 1'b0;
         rate_ff   <= '0;
         rej_ff    <= '0;
         settle_ff <= '0;
         valid_ff  <= 1'b0;
      end else begin
         cfg_ff    <= nxt_cfg;
         rdata_ff  <= nxt_rdata;
         abort_ff  <= nxt_abort;
         rate_ff   <= lk_rate;
         rej_ff    <= lk_rej;
         settle_ff <= lk_settle;
         valid_ff  <= lk_valid;
      end
   end

   // ****************************************************************
   // field decode
   // ****************************************************************
   assign direct_mode       = cfg_ff[DIRECT_BIT];
   assign decim_ratio       = direct_mode ? cfg_ff[RATIO_MSB:0] : '0;
   assign postfilter_enable = !direct_mode && cfg_ff[PF_EN_BIT];
   assign postfilter_select = cfg_ff[PF_SEL_MSB:PF_SEL_LSB];
   assign filter_order      = direct_mode ? ORDER_SINC3
                                          : cfg_ff[ORDER_MSB:ORDER_LSB];
   assign sinc3_selected    = (filter_order == ORDER_SINC3);
   assign output_rate_code  = cfg_ff[RATE_MSB:0];
   // postfilter only acts behind sinc5 plus sinc1
   assign postfilter_active = postfilter_enable &&
                              filter_order == ORDER_SINC5_SINC1;
   assign reg_rdata         = rdata_ff;
   assign conv_abort        = abort_ff;
   assign rate_msps         = rate_ff;
   assign rejection_db      = rej_ff;
   assign settling_us       = settle_ff;
   assign cfg_valid         = valid_ff;

   filter_rate_lookup u_lookup (
      .direct_mode       (direct_mode),
      .postfilter_active (postfilter_active),
      .postfilter_select (postfilter_select),
      .filter_order      (filter_order),
      .output_rate_code  (output_rate_code),
      .rate_msps         (lk_rate),
      .rejection_db      (lk_rej),
      .settling_us       (lk_settle),
      .cfg_valid         (lk_valid)
   );

   // ****************************************************************
   // direct decimation timing
   // ****************************************************************
   conv_state_e state_ff,   nxt_state;
   logic [19:0] div_cnt_ff, nxt_div_cnt;
   logic        tick_ff,    nxt_tick;

   always_comb begin
      nxt_div_cnt = '0;
      nxt_tick    = 1'b0;
      if (direct_mode && decim_ratio != '0 && !abort_ff &&
          state_ff == CONV_RUN) begin
         if (div_cnt_ff >= tick_period(decim_ratio) - 20'h00001) begin
            nxt_tick = 1'b1;
         end else begin
            nxt_div_cnt = div_cnt_ff + 20'h00001;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_cnt_ff <= '0;
         tick_ff    <= 1'b0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
         tick_ff    <= nxt_tick;
      end
   end

   assign direct_tick = tick_ff;

   // ****************************************************************
   // channel sequence
   // ****************************************************************
   logic [CH_W-1:0] chan_ff,  nxt_chan;
   logic            restart_ff, nxt_restart;
   logic            step;

   assign step = direct_mode ? tick_ff : conv_done;

   always_comb begin
      nxt_state   = state_ff;
      nxt_chan    = chan_ff;
      nxt_restart = 1'b0;
      case (state_ff)
         CONV_IDLE: begin
            if (conv_enable) begin
               nxt_state = CONV_RESTART;
            end
         end
         CONV_RESTART: begin
            nxt_chan    = '0;
            nxt_restart = 1'b1;
            nxt_state   = conv_enable ? CONV_RUN : CONV_IDLE;
         end
         CONV_RUN: begin
            if (!conv_enable) begin
               nxt_state = CONV_IDLE;
            end else if (step) begin
               if (chan_ff + 1'b1 >= channel_count) begin
                  nxt_chan = '0;
               end else begin
                  nxt_chan = chan_ff + 1'b1;
               end
            end
         end
         default: nxt_state = CONV_IDLE;
      endcase
      if (abort_ff) begin
         nxt_state = CONV_RESTART;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_ff   <= CONV_IDLE;
         chan_ff    <= '0;
         restart_ff <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         chan_ff    <= nxt_chan;
         restart_ff <= nxt_restart;
      end
   end

   assign channel_idx = chan_ff;
   assign seq_restart = restart_ff;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   logic [19:0] gap_ff;
   always_ff @(posedge core_clk) begin
      if (rst || tick_ff || restart_ff || abort_ff || !direct_mode ||
          state_ff != CONV_RUN) begin
         gap_ff <= '0;
      end else begin
         gap_ff <= gap_ff + 20'h00001;
      end
   end

   a_reset_value: assert property (
      $fell(rst) |-> cfg_ff == FILT_CFG_RESET)
      else $error("filter word reset value wrong");
   a_write_aborts: assert property (
      wr_hit |=> conv_abort ##2 (seq_restart && channel_idx == '0))
      else $error("write did not abort and restart");
   a_direct_ignores: assert property (
      direct_mode |-> !postfilter_active && sinc3_selected)
      else $error("options live in direct mode");
   a_direct_period: assert property (
      $rose(tick_ff) && $past(gap_ff) != '0 && $stable(cfg_ff) |->
         gap_ff == tick_period(decim_ratio) - 20'h00001)
      else $error("direct tick spacing wrong");
   a_reserved_zero: assert property (
      !cfg_ff[DIRECT_BIT] |->
         cfg_ff[RSVD_HI:RSVD_LO] == '0 && !cfg_ff[RSVD_BIT])
      else $error("reserved bits not zero");
   a_pf_enable: assert property (
      wr_hit && !reg_wdata[DIRECT_BIT] |=>
         postfilter_enable == $past(reg_wdata[PF_EN_BIT]))
      else $error("postfilter enable not stored");
   a_pf_twenty: assert property (
      postfilter_active && postfilter_select == PF_20SPS |=>
         rate_msps == PF_RATE_MSPS[2] && settling_us == PF_SETTLE_US[2])
      else $error("20 SPS postfilter figures wrong");
   a_pf_fast: assert property (
      postfilter_active && postfilter_select == PF_27SPS |=>
         rejection_db == PF_REJ_DB[0])
      else $error("27 SPS postfilter figures wrong");
   a_rate_top: assert property (
      !direct_mode && !postfilter_active &&
      output_rate_code <= RATE_CODE_TOP && !filter_order[0] |=>
         rate_msps == RATE_MSPS[0])
      else $error("top rate code wrong");
   a_rate_slow: assert property (
      !direct_mode && !postfilter_active && !filter_order[0] &&
      output_rate_code == RATE_CODE_MAX |=> rate_msps == RATE_MSPS[22])
      else $error("slowest rate code wrong");

   c_write_running: cover property (state_ff == CONV_RUN && wr_hit);
   c_direct_tick:   cover property (direct_mode && tick_ff);
   c_pf_active:     cover property (postfilter_active && cfg_valid);
   c_chan_wrap:     cover property (step && chan_ff != '0 ##1
                                    chan_ff == '0);
endmodule // filter_config_setup_decode

//--- tb/filter_config_setup_decode_tb_top.sv
// Purpose: self-checking bench for the setup 0 filter configuration block
// Assumes: inputs driven at the falling edge, outputs sampled there too
// Notes:   random words stay in listed encodings apart from reserved bits
`timescale 1ns/1ps
`define CHK(g, e, m) \
   begin \
      n_checks++; \
      if ((g) !== (e)) begin \
         miscompares++; \
         $display("CHECK FAILED t=%0t %s", $time, m); \
      end \
   end
module filter_config_setup_decode_tb_top;
   import filter_cfg_pkg::*;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [5:0]  reg_addr = 6'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        conv_enable = 1'b0;
   logic        conv_done = 1'b0;
   logic [3:0]  channel_count = 4'h3;
   logic [15:0] reg_rdata;
   logic        reg_hit, conv_abort, seq_restart, direct_tick, direct_mode;
   logic [3:0]  channel_idx;
   logic [14:0] decim_ratio;
   logic        postfilter_enable, postfilter_active, sinc3_selected;
   logic [2:0]  postfilter_select;
   logic [1:0]  filter_order;
   logic [4:0]  output_rate_code;
   logic [31:0] rate_msps;
   logic [6:0]  rejection_db;
   logic [15:0] settling_us;
   logic        cfg_valid;
   int          miscompares = 0;
   int          n_checks = 0;
   logic [31:0] seed = 32'hA4680675;
   logic [15:0] shadow = 16'h0500;

   always #2 core_clk = ~core_clk;

   filter_config_setup_decode #(.CH_W(4)) filter_config_setup_decode_inst (
      .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_hit(reg_hit), .conv_enable(conv_enable), .conv_done(conv_done),
      .channel_count(channel_count), .conv_abort(conv_abort),
      .seq_restart(seq_restart), .channel_idx(channel_idx),
      .direct_tick(direct_tick), .direct_mode(direct_mode),
      .decim_ratio(decim_ratio), .postfilter_enable(postfilter_enable),
      .postfilter_active(postfilter_active),
      .postfilter_select(postfilter_select),
      .sinc3_selected(sinc3_selected), .filter_order(filter_order),
      .output_rate_code(output_rate_code), .rate_msps(rate_msps),
      .rejection_db(rejection_db), .settling_us(settling_us),
      .cfg_valid(cfg_valid));

   // ****************************************************************
   // expectation functions
   // ****************************************************************
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [15:0] stored(input logic [15:0] w);
      return w[15] ? w : (w & 16'h8F7F);
   endfunction

   // rate in milli samples per second, zero when unlisted
   function automatic logic [31:0] rate_of(input logic [4:0] c);
      logic [31:0] t [0:22];
      t = '{32'h01DCD650, 32'h01DCD650, 32'h01DCD650, 32'h01DCD650,
            32'h01DCD650, 32'h01DCD650, 32'h00EE6B28, 32'h009EF368,
            32'h004F77C0, 32'h0027A088, 32'h000F5D98, 32'h0007AFF8,
            32'h0005D048, 32'h00030E6C, 32'h00018768, 32'h0000E880,
            32'h0000C210, 32'h00004E2A, 32'h000040F6, 32'h00002710,
            32'h00001388, 32'h000009C4, 32'h000004E2};
      return (c <= 5'h16) ? t[c] : 32'h00000000;
   endfunction

   // rejection and settling packed together
   function automatic logic [22:0] pf_of(input logic [2:0] c);
      case (c)
         3'h2: return {7'h2F, 16'h8F5C};
         3'h3: return {7'h3E, 16'h9C40};
         3'h5: return {7'h56, 16'hC350};
         3'h6: return {7'h5C, 16'hEA60};
         default: return 23'h000000;
      endcase
   endfunction

   function automatic logic [31:0] pf_rate_of(input logic [2:0] c);
      case (c)
         3'h2: return 32'h00006978;
         3'h3: return 32'h00005302;
         3'h5: return 32'h00004E20;
         3'h6: return 32'h0000411E;
         default: return 32'h00000000;
      endcase
   endfunction

   function automatic logic [2:0] pick_pf(input logic [1:0] k);
      case (k)
         2'h0: return 3'h2;
         2'h1: return 3'h3;
         2'h2: return 3'h5;
         default: return 3'h6;
      endcase
   endfunction

   function automatic logic valid_of(input logic [15:0] s);
      if (s[11] && s[6:5] == 2'h0) return pf_of(s[10:8]) != 23'h000000;
      return ((s[6:5] == 2'h0) || (s[6:5] == 2'h3)) && (s[4:0] <= 5'h16);
   endfunction

   function automatic logic [15:0] rand_word(input logic [31:0] r);
      if (r[31:29] == 3'h0) return {1'b1, r[14:0]};
      return {1'b0, r[14:12], r[11], pick_pf(r[9:8]), r[7], {2{r[5]}},
              5'(r[20:16] % 23)};
   endfunction

   // ****************************************************************
   // register port tasks
   // ****************************************************************
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic        hit;
      logic        pa;
      logic [15:0] s;
      logic [22:0] pf;
      hit = (a == 6'h28);
      if (hit) shadow = stored(d);
      s = shadow;
      pa = s[11] & ~s[15] & (s[6:5] == 2'h0);
      pf = pf_of(s[10:8]);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
      conv_done = 1'b0;
      `CHK(conv_abort, hit, "abort pulse");
      `CHK(direct_mode, s[15], "direct mode");
      `CHK(decim_ratio, s[15] ? s[14:0] : 15'h0000, "ratio");
      `CHK(postfilter_enable, s[11] & ~s[15], "pf enable");
      `CHK(postfilter_active, pa, "pf active");
      `CHK(postfilter_select, s[10:8], "pf select");
      `CHK(filter_order, s[15] ? 2'h3 : s[6:5], "order");
      `CHK(sinc3_selected, s[15] | (s[6:5] == 2'h3), "sinc3");
      `CHK(output_rate_code, s[4:0], "rate code");
      @(negedge core_clk);
      `CHK(conv_abort, 1'b0, "abort width");
      `CHK(rejection_db, pa ? pf[22:16] : 7'h00, "rejection");
      if (pa) `CHK(settling_us, pf[15:0], "settling");
      if (pa) `CHK(rate_msps, pf_rate_of(s[10:8]), "pf rate");
      if (!s[15] && !pa && s[6:5] == 2'h0)
         `CHK(rate_msps, rate_of(s[4:0]), "rate");
      if (s[15]) `CHK(rate_msps, 32'h00000000, "direct rate");
      if (!s[15]) `CHK(cfg_valid, valid_of(s), "valid");
      @(negedge core_clk);
      if (hit && conv_enable) begin
         `CHK(seq_restart, 1'b1, "restart");
         `CHK(channel_idx, 4'h0, "first channel");
      end
   endtask

   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      `CHK(reg_hit, a == 6'h28, "hit");
      `CHK(reg_rdata, e, "read data");
      reg_rd = 1'b0;
      @(negedge core_clk);
   endtask

   task automatic wait_tick(output int n);
      n = 0;
      while (direct_tick !== 1'b1 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      int b;
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      repeat (2) @(negedge core_clk);
      rd(6'h28, 16'h0500);
      `CHK(rate_msps, 32'h01DCD650, "reset rate");
      `CHK(postfilter_select, 3'h5, "reset pf");
      `CHK(postfilter_enable, 1'b0, "reset pf off");
      conv_enable = 1'b1;
      // reserved bits, unmapped address
      wr(6'h28, 16'h7FFF);
      rd(6'h28, 16'h0F7F);
      wr(6'h29, 16'h1234);
      rd(6'h29, 16'h0000);
      rd(6'h28, 16'h0F7F);
      for (int c = 0; c < 24; c++) wr(6'h28, {11'h000, c[4:0]});
      for (int i = 0; i < 8; i++)
         wr(6'h28, {5'h01, pick_pf(i[1:0]), 1'b0, {2{i[2]}}, 5'h09});
      // channel stepping, then a write in a step cycle
      wr(6'h28, 16'h0500);
      conv_done = 1'b1;
      for (int k = 1; k <= 4; k++) begin
         @(negedge core_clk);
         `CHK(channel_idx, 4'(k % 3), "step");
      end
      wr(6'h28, 16'h0560);
      // direct decimation, ratio 2
      wr(6'h28, 16'h8002);
      conv_done = 1'b1;
      @(negedge core_clk);
      conv_done = 1'b0;
      `CHK(channel_idx, 4'h0, "done ignored");
      wait_tick(b);
      @(negedge core_clk);
      `CHK(channel_idx, 4'h1, "tick step");
      wait_tick(b);
      `CHK(b, 63, "tick spacing");
      wr(6'h28, 16'h8000);
      b = 0;
      repeat (150) begin
         @(negedge core_clk);
         if (direct_tick === 1'b1) b++;
      end
      `CHK(b, 0, "ratio zero");
      repeat (40) begin
         wr(6'h28, rand_word(xs()));
         rd(6'h28, shadow);
      end
      // second reset in mid-run
      rst = 1'b1;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      repeat (2) @(negedge core_clk);
      `CHK(cfg_valid, 1'b1, "reset valid again");
      `CHK(rate_msps, 32'h01DCD650, "reset rate again");
      rd(6'h28, 16'h0500);
      conclude();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      conclude();
   end
endmodule // filter_config_setup_decode_tb_top
